// *** hdl/crp_pkg.sv ***
// Constants shared by the receive bookkeeping block and its match unit
package crp_pkg;

  localparam int NUM_MB      = 16;
  localparam int ID_W        = 29;
  localparam int STD_LSB     = 18;
  localparam int IRQ_W       = 4;

  // Register indices; byte address is four times the index
  localparam logic [9:0] PEND_LO_IDX  = 10'h30C;
  localparam logic [9:0] PEND_HI_IDX  = 10'h30D;
  localparam logic [9:0] LOST_LO_IDX  = 10'h30E;
  localparam logic [9:0] LOST_HI_IDX  = 10'h30F;
  localparam logic [9:0] RFP_LO_IDX   = 10'h32C;
  localparam logic [9:0] RFP_HI_IDX   = 10'h32D;
  localparam logic [9:0] DIR_LO_IDX   = 10'h350;
  localparam logic [9:0] DIR_HI_IDX   = 10'h351;
  localparam logic [9:0] AREP_LO_IDX  = 10'h352;
  localparam logic [9:0] AREP_HI_IDX  = 10'h353;
  localparam logic [9:0] MEN_LO_IDX   = 10'h354;
  localparam logic [9:0] MEN_HI_IDX   = 10'h355;
  localparam logic [9:0] TRQ_LO_IDX   = 10'h356;
  localparam logic [9:0] TRQ_HI_IDX   = 10'h357;
  localparam logic [9:0] IRQ_STAT_IDX = 10'h358;
  localparam logic [9:0] IRQ_MASK_IDX = 10'h359;
  localparam logic [9:0] GMASK_IDX    = 10'h360;
  localparam logic [9:0] LMASK_IDX    = 10'h364;
  localparam logic [3:0] MBID_SEL     = 4'hE;

  // Reset values
  localparam logic [15:0] FLAGS_RST   = 16'h0000;
  localparam logic [31:0] WORD_RST    = 32'h0000_0000;
  localparam logic [3:0]  IRQ_RST     = 4'h0;

  // Identifier word layout: IDE in bit 31, bits 30..29 read zero
  localparam int          IDE_BIT     = 31;
  localparam logic [31:0] ID_RD_MASK  = 32'h9FFF_FFFF;

  // Interrupt status bit positions
  localparam int IRQ_RX_STORED = 0;
  localparam int IRQ_RX_LOST   = 1;
  localparam int IRQ_AUTO_REP  = 2;
  localparam int IRQ_RX_REMOTE = 3;

endpackage

// *** hdl/crp_id_match.sv ***
// Identifier comparison of one mailbox against an incoming frame
`timescale 1ns/100ps

module crp_id_match
  import crp_pkg::*;
(
  input  wire logic [ID_W-1:0] frame_id,
  input  wire logic            frame_ide,
  input  wire logic [ID_W-1:0] mb_id,
  input  wire logic            mb_ide,
  input  wire logic [ID_W-1:0] mask,
  input  wire logic            ide_mask,
  input  wire logic            mask_en,
  output logic                 hit
);

  logic [ID_W-1:0] diff;
  logic            ide_ok;

  // A set mask bit makes that identifier bit a don't-care
  assign diff   = (frame_id ^ mb_id) & ~(mask_en ? mask : '0);
  assign ide_ok = (mask_en & ide_mask) | (frame_ide == mb_ide);
  // Standard frames compare only the upper eleven identifier bits
  assign hit    = ide_ok & (frame_ide ? ~|diff : ~|diff[ID_W-1:STD_LSB]);

endmodule

// *** hdl/crp_rx_book.sv ***
// Receive pending, lost and remote frame bookkeeping for 16 mailboxes
`timescale 1ns/100ps

// What this block does
// R1: Pending flag per mailbox, set on store
// R2: Store onto pending mailbox sets lost flag
// R3: CPU writing one clears pending bit
// R4: Lost set by hardware, cleared via pending
// R5: Unmatched frame changes no flag
// R6: Remote frames compared against all mailboxes
// R7: Comparison honours mask enables and masks
// R8: Remote match, transmit, auto-reply: request transmit
// R9: Auto-reply off: no transmit request
// R10: Remote into receive mailbox sets pending, remote
// R11: First matching mailbox only takes frame
// R12: Global mask reply rewrites mailbox identifier
// R13: Mailbox 15 compared only if none matched
// R14: Remote flag cleared by pending clear, data
// R15: Hardware set beats simultaneous CPU clear

module crp_rx_book
  import crp_pkg::*;
#(
  parameter int MB_COUNT = NUM_MB
)
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic            frame_valid,
  input  wire logic            frame_remote,
  input  wire logic            frame_ide,
  input  wire logic [ID_W-1:0] frame_id,
  input  wire logic [14:0]     tx_done,
  output logic                 store_valid,
  output logic      [3:0]      store_mailbox,
  output logic      [14:0]     tx_request,
  output logic                 irq
);

  if (MB_COUNT != 16)
  begin : g_bad_count
    $error("crp_rx_book serves exactly 16 mailboxes");
  end

  logic [15:0]      pend_reg;
  logic [15:0]      lost_reg;
  logic [15:0]      rfp_reg;
  logic [14:0]      dir_tx_reg;
  logic [14:0]      arep_reg;
  logic [15:0]      men_reg;
  logic [14:0]      trq_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [31:0]      gmask_reg;
  logic [31:0]      lmask_reg;
  logic [31:0]      mb_id_reg [16];
  logic             store_valid_reg;
  logic [3:0]       store_mb_reg;

  logic [9:0]       idx;
  logic             wr_en;
  logic [15:0]      pend_clr;
  logic [15:0]      dir_tx;
  logic [15:0]      hit_raw;
  logic [15:0]      hit;
  logic             sel_valid;
  logic [3:0]       sel_idx;
  logic [15:0]      sel_oh;
  logic             do_store;
  logic             do_reply;
  logic [15:0]      store_oh;
  logic [15:0]      reply_oh;
  logic [IRQ_W-1:0] irq_ev;
  logic [7:0]       rd_byte;
  logic             mapped;

  assign idx    = paddr[11:2];
  assign wr_en  = psel & penable & pwrite & mapped;
  assign pready = 1'b1;
  // Mailbox 15 is receive-only, so its direction bit is fixed
  assign dir_tx = {1'b0, dir_tx_reg};

  // Pending clear strobes from a one written to the pending bytes
  always_comb
  begin
    pend_clr = 16'h0000;
    if (wr_en && idx == PEND_LO_IDX)
    begin
      pend_clr[7:0] = pwdata[7:0]; // R3
    end
    else if (wr_en && idx == PEND_HI_IDX)
    begin
      pend_clr[15:8] = pwdata[7:0]; // R3
    end
  end

  // Comparators for mailboxes 0..14 share the global mask
  for (genvar n = 0; n < 15; n++)
  begin : g_match
    crp_id_match u_match (
      .frame_id  (frame_id),
      .frame_ide (frame_ide),
      .mb_id     (mb_id_reg[n][ID_W-1:0]),
      .mb_ide    (mb_id_reg[n][IDE_BIT]),
      .mask      (gmask_reg[ID_W-1:0]),
      .ide_mask  (gmask_reg[IDE_BIT]),
      .mask_en   (men_reg[n]),
      .hit       (hit_raw[n])
    ); // R7
  end

  // Mailbox 15 uses the local mask only
  crp_id_match u_match_last (
    .frame_id  (frame_id),
    .frame_ide (frame_ide),
    .mb_id     (mb_id_reg[15][ID_W-1:0]),
    .mb_ide    (mb_id_reg[15][IDE_BIT]),
    .mask      (lmask_reg[ID_W-1:0]),
    .ide_mask  (lmask_reg[IDE_BIT]),
    .mask_en   (men_reg[15]),
    .hit       (hit_raw[15])
  ); // R7

  // Data frames look at receive mailboxes, remote frames at all
  always_comb
  begin
    hit[14:0] = hit_raw[14:0] & (~dir_tx[14:0] | {15{frame_remote}}); // R6
    hit[15]   = hit_raw[15] & ~|hit[14:0]; // R13
  end

  // Lowest matching index wins; later mailboxes never see the frame
  always_comb
  begin
    sel_valid = 1'b0;
    sel_idx   = 4'h0;
    for (int i = 15; i >= 0; i--)
    begin
      if (hit[i])
      begin
        sel_valid = 1'b1; // R11
        sel_idx   = 4'(i);
      end
    end
  end

  always_comb
  begin
    sel_oh   = 16'h0001 << sel_idx;
    // No hit means no store and no reply
    do_store = frame_valid & sel_valid & ~dir_tx[sel_idx]; // R5 R10
    do_reply = frame_valid & sel_valid & frame_remote & dir_tx[sel_idx]
               & arep_reg[sel_idx[3:0] == 4'hF ? 4'h0 : sel_idx]; // R8 R9
    store_oh = do_store ? sel_oh : 16'h0000;
    reply_oh = do_reply ? sel_oh : 16'h0000;
  end

  // Set applied after clear so a simultaneous event is kept
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_reg <= FLAGS_RST;
    end
    else
    begin
      pend_reg <= (pend_reg & ~pend_clr) | store_oh; // R1 R3 R15
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lost_reg <= FLAGS_RST;
    end
    else
    begin
      // Lost rises only on a store over a still pending mailbox
      lost_reg <= (lost_reg & ~pend_clr) | (store_oh & pend_reg); // R2 R4 R15
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rfp_reg <= FLAGS_RST;
    end
    else if (frame_remote)
    begin
      rfp_reg <= (rfp_reg & ~pend_clr) | store_oh; // R10 R15
    end
    else
    begin
      rfp_reg <= rfp_reg & ~pend_clr & ~store_oh; // R14
    end
  end

  // Transmit requests clear on completion or abort from the engine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trq_reg <= FLAGS_RST[14:0];
    end
    else
    begin
      trq_reg <= (trq_reg & ~tx_done) | reply_oh[14:0]; // R8
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      store_valid_reg <= 1'b0;
      store_mb_reg    <= 4'h0;
    end
    else
    begin
      store_valid_reg <= do_store; // R2
      store_mb_reg    <= sel_idx;
    end
  end

  // Mailbox configuration written by software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dir_tx_reg <= FLAGS_RST[14:0];
      arep_reg   <= FLAGS_RST[14:0];
      men_reg    <= FLAGS_RST;
    end
    else if (wr_en)
    begin
      if (idx == DIR_LO_IDX)
      begin
        dir_tx_reg[7:0] <= pwdata[7:0];
      end
      else if (idx == DIR_HI_IDX)
      begin
        dir_tx_reg[14:8] <= pwdata[6:0];
      end
      else if (idx == AREP_LO_IDX)
      begin
        arep_reg[7:0] <= pwdata[7:0];
      end
      else if (idx == AREP_HI_IDX)
      begin
        arep_reg[14:8] <= pwdata[6:0];
      end
      else if (idx == MEN_LO_IDX)
      begin
        men_reg[7:0] <= pwdata[7:0];
      end
      else if (idx == MEN_HI_IDX)
      begin
        men_reg[15:8] <= pwdata[7:0];
      end
    end
  end

  // Masks should only change while the bus is idle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gmask_reg <= WORD_RST;
      lmask_reg <= WORD_RST;
    end
    else
    begin
      for (int k = 0; k < 4; k++)
      begin
        if (wr_en && idx == GMASK_IDX + 10'(k))
        begin
          gmask_reg[8*k +: 8] <= pwdata[7:0];
        end
        if (wr_en && idx == LMASK_IDX + 10'(k))
        begin
          lmask_reg[8*k +: 8] <= pwdata[7:0];
        end
      end
    end
  end

  // Identifier words; an auto reply under global mask overrides a write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int m = 0; m < 16; m++)
      begin
        mb_id_reg[m] <= WORD_RST;
      end
    end
    else
    begin
      if (wr_en && idx[9:6] == MBID_SEL)
      begin
        mb_id_reg[idx[5:2]][8*idx[1:0] +: 8] <= pwdata[7:0];
      end
      if (do_reply && men_reg[sel_idx])
      begin
        mb_id_reg[sel_idx] <= {frame_ide, 2'b00, frame_id}; // R12
      end
    end
  end

  always_comb
  begin
    irq_ev                = '0;
    irq_ev[IRQ_RX_STORED] = do_store;
    irq_ev[IRQ_RX_LOST]   = |(store_oh & pend_reg);
    irq_ev[IRQ_AUTO_REP]  = do_reply;
    irq_ev[IRQ_RX_REMOTE] = do_store & frame_remote;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat_reg <= IRQ_RST;
    end
    else if (wr_en && idx == IRQ_STAT_IDX)
    begin
      irq_stat_reg <= (irq_stat_reg & ~pwdata[IRQ_W-1:0]) | irq_ev;
    end
    else
    begin
      irq_stat_reg <= irq_stat_reg | irq_ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_mask_reg <= IRQ_RST;
    end
    else if (wr_en && idx == IRQ_MASK_IDX)
    begin
      irq_mask_reg <= pwdata[IRQ_W-1:0];
    end
  end

  // Read decode; unmapped addresses answer with an error
  always_comb
  begin
    mapped  = 1'b1;
    rd_byte = 8'h00;
    if (idx == PEND_LO_IDX)
    begin
      rd_byte = pend_reg[7:0];
    end
    else if (idx == PEND_HI_IDX)
    begin
      rd_byte = pend_reg[15:8];
    end
    else if (idx == LOST_LO_IDX)
    begin
      rd_byte = lost_reg[7:0]; // R4
    end
    else if (idx == LOST_HI_IDX)
    begin
      rd_byte = lost_reg[15:8]; // R4
    end
    else if (idx == RFP_LO_IDX)
    begin
      rd_byte = rfp_reg[7:0];
    end
    else if (idx == RFP_HI_IDX)
    begin
      rd_byte = rfp_reg[15:8];
    end
    else if (idx == DIR_LO_IDX)
    begin
      rd_byte = dir_tx_reg[7:0];
    end
    else if (idx == DIR_HI_IDX)
    begin
      rd_byte = {1'b0, dir_tx_reg[14:8]};
    end
    else if (idx == AREP_LO_IDX)
    begin
      rd_byte = arep_reg[7:0];
    end
    else if (idx == AREP_HI_IDX)
    begin
      rd_byte = {1'b0, arep_reg[14:8]};
    end
    else if (idx == MEN_LO_IDX)
    begin
      rd_byte = men_reg[7:0];
    end
    else if (idx == MEN_HI_IDX)
    begin
      rd_byte = men_reg[15:8];
    end
    else if (idx == TRQ_LO_IDX)
    begin
      rd_byte = trq_reg[7:0];
    end
    else if (idx == TRQ_HI_IDX)
    begin
      rd_byte = {1'b0, trq_reg[14:8]};
    end
    else if (idx == IRQ_STAT_IDX)
    begin
      rd_byte = {4'h0, irq_stat_reg};
    end
    else if (idx == IRQ_MASK_IDX)
    begin
      rd_byte = {4'h0, irq_mask_reg};
    end
    else if (idx[9:2] == GMASK_IDX[9:2])
    begin
      rd_byte = gmask_reg[8*idx[1:0] +: 8];
    end
    else if (idx[9:2] == LMASK_IDX[9:2])
    begin
      rd_byte = lmask_reg[8*idx[1:0] +: 8];
    end
    else if (idx[9:6] == MBID_SEL)
    begin
      rd_byte = 8'((mb_id_reg[idx[5:2]] & ID_RD_MASK) >> (8*idx[1:0]));
    end
    else
    begin
      mapped = 1'b0;
    end
  end

  assign prdata        = {24'h000000, rd_byte};
  assign pslverr       = psel & penable & ~mapped;
  assign store_valid   = store_valid_reg;
  assign store_mailbox = store_mb_reg;
  assign tx_request    = trq_reg;
  assign irq           = |(irq_stat_reg & irq_mask_reg);

endmodule

// *** verification/crp_rx_book_chk.sv ***
// Port checker for the receive bookkeeping block
`timescale 1ns/100ps

module crp_rx_book_chk
  import crp_pkg::*;
#(
  parameter int MB_COUNT = NUM_MB
)
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        frame_valid,
  input wire logic        frame_remote,
  input wire logic [14:0] tx_done,
  input wire logic        store_valid,
  input wire logic [14:0] tx_request
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence data_s;
    frame_valid && !frame_remote;
  endsequence
  // A request bit that was not there one edge earlier
  sequence tx_new_s;
    |(tx_request & ~$past(tx_request));
  endsequence

  store_cause_a: assert property (store_valid |-> $past(frame_valid))
    else $error("store pulse without a frame");
  tx_cause_a: assert property (tx_new_s |-> $past(frame_remote && frame_valid))
    else $error("transmit request without remote frame");
  data_no_req_a: assert property (not (data_s ##1 tx_new_s))
    else $error("data frame raised a transmit request");
  reply_nostore_a: assert property (tx_new_s |-> !store_valid)
    else $error("auto reply also stored the frame");
  reply_one_a: assert property (tx_new_s |->
    $onehot(tx_request & ~$past(tx_request)))
    else $error("one frame raised several requests");
  tx_hold_a: assert property
    (($past(tx_request) & ~tx_request & ~$past(tx_done)) == 15'h0000)
    else $error("transmit request dropped without done");
  zero_wait_a: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  err_zero_a: assert property
    (pslverr |-> psel && penable && prdata == 32'h0000_0000)
    else $error("error response outside access or with data");
  rd_upper_a: assert property
    (psel && penable && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  cover property (data_s ##1 store_valid);
endmodule

bind crp_rx_book crp_rx_book_chk #(.MB_COUNT(MB_COUNT)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .frame_valid(frame_valid), .frame_remote(frame_remote),
  .tx_done(tx_done), .store_valid(store_valid), .tx_request(tx_request)
);

// *** verification/crp_node_model.sv ***
// Far side model: frames from the bus and transmit completion
`timescale 1ns/100ps

module crp_node_model
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  dly,
  input  wire logic [14:0] tx_request,
  output logic      [14:0] tx_done,
  output logic             frame_valid,
  output logic             frame_remote,
  output logic             frame_ide,
  output logic      [28:0] frame_id
);
  logic [28:0] id_q;
  logic        rem_q;
  logic        ide_q;
  logic [7:0]  cnt;

  // Idle lines show the inverse of the last frame, so stale values never match
  assign frame_id     = frame_valid ? id_q : ~id_q;
  assign frame_remote = frame_valid ? rem_q : ~rem_q;
  assign frame_ide    = frame_valid ? ide_q : ~ide_q;

  initial
  begin
    frame_valid = 1'b0;
    id_q = 29'h0;
    rem_q = 1'b0;
    ide_q = 1'b1;
  end

  task automatic send(input logic r, input logic [28:0] id);
    frame_valid <= 1'b1;
    rem_q       <= r;
    id_q        <= id;
    @(posedge pclk);
    frame_valid <= 1'b0;
  endtask

  // Standard format data frame; extended format is restored afterwards
  task automatic send_std(input logic [28:0] id);
    ide_q <= 1'b0;
    send(1'b0, id);
    ide_q <= 1'b1;
  endtask

  // Lowest request completes dly+1 cycles after it appears; dly of 0 answers on the next edge
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cnt     <= 8'h00;
      tx_done <= 15'h0000;
    end
    else
    begin
      if (tx_request == 15'h0000 || tx_done != 15'h0000)
      begin
        cnt     <= 8'h00;
        tx_done <= 15'h0000;
      end
      else if (cnt >= dly)
        tx_done <= tx_request & (~tx_request + 15'h0001);
      else
        cnt <= cnt + 8'h01;
    end
endmodule

// *** verification/tb.sv ***
// Testbench for the receive bookkeeping block
`timescale 1ns/100ps

module tb
  import crp_pkg::*;
;
  localparam logic [28:0] ID_A = 29'h0123_4567;
  localparam logic [28:0] ID_B = 29'h0123_4568;
  localparam logic [28:0] ID_C = 29'h0765_4321;
  localparam logic [28:0] ID_D = 29'h1555_5500;
  localparam logic [28:0] ID_F = 29'h1555_555A;
  localparam logic [28:0] ID_E = 29'h0F0F_0F0F;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, w;
  logic        pready, pslverr, er, irq, store_valid;
  logic        frame_valid, frame_remote, frame_ide;
  logic [28:0] frame_id;
  logic [14:0] tx_done, tx_request;
  logic [3:0]  store_mailbox;
  logic [7:0]  dly;
  int          n_errors, samples_checked;

  crp_rx_book i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_valid(frame_valid), .frame_remote(frame_remote),
    .frame_ide(frame_ide), .frame_id(frame_id), .tx_done(tx_done),
    .store_valid(store_valid), .store_mailbox(store_mailbox),
    .tx_request(tx_request), .irq(irq));
  crp_node_model i_node (.pclk(pclk), .presetn(presetn), .dly(dly),
    .tx_request(tx_request), .tx_done(tx_done), .frame_valid(frame_valid),
    .frame_remote(frame_remote), .frame_ide(frame_ide), .frame_id(frame_id));

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic wrap_up();
    $display("mismatches %0d of %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic stuck();
    n_errors++;
    $display("[FAIL] %0t wait ran out", $time);
    wrap_up();
  endtask

  task automatic apb(input logic wr, input logic [9:0] ix, input logic [7:0] d);
    int k;
    k = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {ix, 2'b00};
    pwdata  <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      if (++k > 50)
        stuck();
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdc(input logic [9:0] ix, input logic [7:0] e);
    apb(1'b0, ix, 8'h00);
    chk(rd, {24'h00_0000, e});
  endtask

  task automatic set_id(input int n, input logic [28:0] id);
    for (int b = 0; b < 4; b++)
      apb(1'b1, 10'h380 + 10'(4 * n + b), 8'({3'b100, id} >> (8 * b)));
  endtask

  // Store pulse, its mailbox and the request flags after the frame edge
  task automatic frame(input logic r, input logic [28:0] id, input logic s,
                       input logic [3:0] m, input logic [14:0] t);
    i_node.send(r, id);
    #1;
    chk({12'h000, store_valid, store_valid ? store_mailbox : 4'h0, tx_request},
        {12'h000, s, m, t});
    @(posedge pclk);
  endtask

  task automatic wait_tx();
    int k;
    k = 0;
    while (tx_request !== 15'h0000)
    begin
      if (++k > 500)
        stuck();
      @(posedge pclk);
    end
  endtask

  task automatic s_regs();
    rdc(PEND_LO_IDX, 8'h00);
    rdc(PEND_HI_IDX, 8'h00);
    rdc(LOST_LO_IDX, 8'h00);
    rdc(LOST_HI_IDX, 8'h00);
    apb(1'b0, 10'h000, 8'h00);
    chk({er, rd[30:0]}, 32'h8000_0000);
  endtask

  task automatic s_store();
    set_id(3, ID_A);
    frame(1'b0, ID_A, 1'b1, 4'h3, 15'h0000);
    rdc(LOST_LO_IDX, 8'h00);
    frame(1'b0, ID_A, 1'b1, 4'h3, 15'h0000);
    rdc(LOST_LO_IDX, 8'h08);
    apb(1'b1, LOST_LO_IDX, 8'hFF);
    rdc(LOST_LO_IDX, 8'h08);
    apb(1'b1, PEND_LO_IDX, 8'h00);
    rdc(PEND_LO_IDX, 8'h08);
    apb(1'b1, PEND_LO_IDX, 8'h08);
    rdc(PEND_LO_IDX, 8'h00);
    rdc(LOST_LO_IDX, 8'h00);
    frame(1'b0, ID_B, 1'b0, 4'h0, 15'h0000);
    rdc(PEND_LO_IDX, 8'h00);
  endtask

  task automatic s_race();
    frame(1'b0, ID_A, 1'b1, 4'h3, 15'h0000);
    fork
      apb(1'b1, PEND_LO_IDX, 8'h08);
      begin
        @(posedge pclk);
        i_node.send(1'b0, ID_A);
      end
    join
    rdc(PEND_LO_IDX, 8'h08);
    rdc(LOST_LO_IDX, 8'h08);
    apb(1'b1, PEND_LO_IDX, 8'h08);
  endtask

  task automatic s_remote_rx();
    apb(1'b1, AREP_LO_IDX, 8'h08);
    frame(1'b1, ID_A, 1'b1, 4'h3, 15'h0000);
    rdc(RFP_LO_IDX, 8'h08);
    frame(1'b0, ID_A, 1'b1, 4'h3, 15'h0000);
    rdc(RFP_LO_IDX, 8'h00);
    frame(1'b1, ID_A, 1'b1, 4'h3, 15'h0000);
    apb(1'b1, PEND_LO_IDX, 8'h08);
    rdc(RFP_LO_IDX, 8'h00);
    rdc(PEND_LO_IDX, 8'h00);
  endtask

  task automatic s_reply();
    set_id(1, ID_C);
    set_id(4, ID_C);
    apb(1'b1, DIR_LO_IDX, 8'h32);
    apb(1'b1, AREP_LO_IDX, 8'h10);
    frame(1'b1, ID_C, 1'b0, 4'h0, 15'h0000);
    frame(1'b1, ID_B, 1'b0, 4'h0, 15'h0000);
    apb(1'b1, AREP_LO_IDX, 8'h32);
    frame(1'b1, ID_C, 1'b0, 4'h0, 15'h0002);
    wait_tx();
    set_id(5, ID_D);
    apb(1'b1, GMASK_IDX, 8'hFF);
    frame(1'b1, ID_F, 1'b0, 4'h0, 15'h0000);
    apb(1'b1, MEN_LO_IDX, 8'h20);
    frame(1'b1, ID_F, 1'b0, 4'h0, 15'h0020);
    for (int b = 0; b < 4; b++)
    begin
      apb(1'b0, 10'h394 + 10'(b), 8'h00);
      w[8 * b +: 8] = rd[7:0];
    end
    chk(w, {3'b100, ID_F});
    wait_tx();
  endtask

  task automatic s_last_mb();
    set_id(6, ID_E);
    set_id(15, ID_E);
    frame(1'b0, ID_E, 1'b1, 4'h6, 15'h0000);
    apb(1'b1, 10'h39B, 8'h00);
    frame(1'b0, ID_E, 1'b1, 4'hF, 15'h0000);
    rdc(PEND_HI_IDX, 8'h80);
    apb(1'b1, LMASK_IDX, 8'hFF);
    frame(1'b0, 29'h0F0F_0FF0, 1'b0, 4'h0, 15'h0000);
    apb(1'b1, MEN_HI_IDX, 8'h80);
    frame(1'b0, 29'h0F0F_0FF0, 1'b1, 4'hF, 15'h0000);
  endtask

  // Standard frames compare only the upper eleven identifier bits
  task automatic s_std();
    i_node.send_std(29'h0003_FFFF);
    #1;
    chk({27'h0, store_valid, store_mailbox}, {27'h0, 1'b1, 4'h0});
    @(posedge pclk);
    rdc(PEND_LO_IDX, 8'h41);
  endtask

  task automatic s_irq();
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, IRQ_MASK_IDX, 8'h01);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, IRQ_STAT_IDX, 8'h0F);
    chk({31'h0, irq}, 32'h0);
    frame(1'b0, ID_A, 1'b1, 4'h3, 15'h0000);
    chk({31'h0, irq}, 32'h1);
    frame(1'b1, ID_A, 1'b1, 4'h3, 15'h0000);
    rdc(IRQ_STAT_IDX, 8'h0B);
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    dly = 8'h1E;
    n_errors = 0;
    samples_checked = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_regs();
    s_store();
    s_race();
    s_remote_rx();
    s_reply();
    s_last_mb();
    s_std();
    s_irq();
    wrap_up();
  end
endmodule
